// ### hdl/iabm_pkg.sv
package iabm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_MODULE_CONFIG = 8'h00;
  localparam logic [7:0] OFF_AUTOVECTOR_SELECT = 8'h04;
  localparam logic [7:0] OFF_PROTECTION_CONFIG = 8'h08;
  localparam logic [7:0] OFF_TIMER_VECTOR = 8'h0c;
  localparam logic [7:0] OFF_WATCHDOG_VECTOR = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Field layouts
  localparam int ARB_W = 4;
  localparam int ARB_LSB = 0;
  localparam int LEVELS = 7;
  localparam int AVR_LSB = 0;
  localparam int BWE_BIT = 7;
  localparam int BML_LSB = 4;
  localparam int BML_W = 2;
  localparam int VEC_W = 8;
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_SPURIOUS_BIT = 1;
  localparam int ST_WINNER_LSB = 4;
  localparam int ST_IPL_LSB = 8;

  // Reset values
  localparam logic [ARB_W-1:0] ARB_RESET = 4'hf;
  localparam logic [ARB_W-1:0] CPM_ARB = 4'h8;
  localparam logic [LEVELS-1:0] AVR_RESET = 7'h00;
  localparam logic [BML_W-1:0] BML_RESET = 2'h3;
  localparam logic BWE_RESET = 1'b1;
  localparam logic [VEC_W-1:0] TIMER_VEC_RESET = 8'h0f;
  localparam logic [VEC_W-1:0] WATCHDOG_VEC_RESET = 8'h0f;

  // Bus watch limit: base count shifted by the select field (128 .. 1024)
  localparam int BM_CNT_W = 11;
  localparam logic [BM_CNT_W-1:0] BM_BASE_CYCLES = 11'h080;

  typedef enum logic [2:0] {
    IABM_WIN_NONE = 3'h0,
    IABM_WIN_WATCHDOG = 3'h1,
    IABM_WIN_TIMER = 3'h2,
    IABM_WIN_EXT_AUTO = 3'h3,
    IABM_WIN_EXT_VEC = 3'h4,
    IABM_WIN_CPM = 3'h5,
    IABM_WIN_SPURIOUS = 3'h6
  } iabm_winner_t;

  typedef enum logic [2:0] {
    IABM_ST_IDLE = 3'b001,
    IABM_ST_ACK = 3'b010,
    IABM_ST_BUS = 3'b100
  } iabm_state_t;

endpackage

// ### hdl/iabm_level_encoder.sv
module iabm_level_encoder #(
  parameter int N = 7
) (
  input wire logic [N-1:0] pending,
  output logic [2:0] level
);

  // Highest set bit wins; bit i stands for level i+1
  always_comb begin
    level = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (pending[i]) begin
        level = 3'((i + 1));
      end
    end
  end

endmodule // iabm_level_encoder

// ### hdl/iabm_bus_watch.sv
module iabm_bus_watch (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [iabm_pkg::BM_CNT_W-1:0] limit,
  output logic expired
);

  logic [iabm_pkg::BM_CNT_W-1:0] count_q;

  // Count clock cycles while the strobe is held and no termination seen
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (!run) begin
      count_q <= '0;
    end else if (count_q != limit) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign expired = run && (count_q == limit);

endmodule // iabm_bus_watch

// ### hdl/iabm_top.sv
// How it works
// - Module beats COMMUNICATION_PROCESSOR_MODULE at reset; below 8 reverses
// - Timer wins acknowledge: drive its 8-bit vector
// - Watchdog answers with its programmable vector
// - Timer and watchdog never autovectored
// - External lines vectored or autovectored
// - Arbitration value from config field; avoid 8
// - Seven external levels, one autovector bit each
// - Autovector bit set gives internal autovector
// - Level 7: watchdog, then timer, then external
// - Timer beats external at same lower level
// - Bus watch times every strobe assertion
// - Acknowledge, error, stop, autovector end timing
// - Overlong cycle raises bus error
// - Bus watch runs only when enabled
// - Limit counted in clocks, 128 to 1024
// - Internal sources arbitrate on acknowledge cycle
module iabm_top (
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core bus cycle
  input wire logic address_strobe,
  input wire logic iack_cycle,
  input wire logic [2:0] iack_level,
  input wire logic data_size_acknowledge,
  input wire logic bus_error_in,
  input wire logic stop_request,
  input wire logic autovector_request,
  // Interrupt sources
  input wire logic timer_req,
  input wire logic [2:0] timer_level,
  input wire logic watchdog_req,
  input wire logic [2:0] watchdog_level,
  input wire logic [iabm_pkg::LEVELS-1:0] external_request_lines,
  input wire logic cpm_req,
  input wire logic [2:0] cpm_level,
  // Responses
  output logic [2:0] ipl_out,
  output logic [iabm_pkg::VEC_W-1:0] vector_out,
  output logic vector_valid,
  output logic autovector_out,
  output logic cpm_grant,
  output logic ext_grant,
  output logic bus_error_signal
);

  logic [iabm_pkg::ARB_W-1:0] arb_q;
  logic [iabm_pkg::LEVELS-1:0] avr_q;
  logic bwe_q;
  logic [iabm_pkg::BML_W-1:0] bml_q;
  logic [iabm_pkg::VEC_W-1:0] timer_vec_q;
  logic [iabm_pkg::VEC_W-1:0] watchdog_vec_q;
  logic timeout_seen_q;
  logic spurious_seen_q;
  iabm_pkg::iabm_winner_t winner_q;
  iabm_pkg::iabm_winner_t winner_d;
  iabm_pkg::iabm_state_t state_q;
  iabm_pkg::iabm_state_t state_d;
  logic [31:0] prdata_q;
  logic [iabm_pkg::VEC_W-1:0] vector_q;
  logic vector_valid_q;
  logic autovector_q;
  logic cpm_grant_q;
  logic ext_grant_q;
  logic bus_error_signal_q;
  logic [iabm_pkg::LEVELS-1:0] pending;
  logic [iabm_pkg::BM_CNT_W-1:0] bm_limit;
  logic bm_run;
  logic bm_expired;
  logic terminated;
  logic spurious_hit;
  logic setup_phase;
  logic wr_en;
  logic addr_hit;
  logic st_clear_timeout;
  logic st_clear_spurious;
  logic ack_start;

  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign ack_start = (state_q == iabm_pkg::IABM_ST_IDLE) && address_strobe && iack_cycle;

  always_comb begin
    unique case (paddr)
      iabm_pkg::OFF_MODULE_CONFIG,
      iabm_pkg::OFF_AUTOVECTOR_SELECT,
      iabm_pkg::OFF_PROTECTION_CONFIG,
      iabm_pkg::OFF_TIMER_VECTOR,
      iabm_pkg::OFF_WATCHDOG_VECTOR,
      iabm_pkg::OFF_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // No wait states: read data registered in setup, answered in access
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        iabm_pkg::OFF_MODULE_CONFIG: begin
          prdata_q[iabm_pkg::ARB_LSB +: iabm_pkg::ARB_W] <= arb_q;
        end
        iabm_pkg::OFF_AUTOVECTOR_SELECT: begin
          prdata_q[iabm_pkg::AVR_LSB +: iabm_pkg::LEVELS] <= avr_q;
        end
        iabm_pkg::OFF_PROTECTION_CONFIG: begin
          prdata_q[iabm_pkg::BWE_BIT] <= bwe_q;
          prdata_q[iabm_pkg::BML_LSB +: iabm_pkg::BML_W] <= bml_q;
        end
        iabm_pkg::OFF_TIMER_VECTOR: begin
          prdata_q[iabm_pkg::VEC_W-1:0] <= timer_vec_q;
        end
        iabm_pkg::OFF_WATCHDOG_VECTOR: begin
          prdata_q[iabm_pkg::VEC_W-1:0] <= watchdog_vec_q;
        end
        iabm_pkg::OFF_STATUS: begin
          prdata_q[iabm_pkg::ST_TIMEOUT_BIT] <= timeout_seen_q;
          prdata_q[iabm_pkg::ST_SPURIOUS_BIT] <= spurious_seen_q;
          prdata_q[iabm_pkg::ST_WINNER_LSB +: 3] <= winner_q;
          prdata_q[iabm_pkg::ST_IPL_LSB +: 3] <= ipl_out;
        end
        default: begin
          prdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      arb_q <= iabm_pkg::ARB_RESET;
    end else if (wr_en && paddr == iabm_pkg::OFF_MODULE_CONFIG) begin
      arb_q <= pwdata[iabm_pkg::ARB_LSB +: iabm_pkg::ARB_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      avr_q <= iabm_pkg::AVR_RESET;
    end else if (wr_en && paddr == iabm_pkg::OFF_AUTOVECTOR_SELECT) begin
      avr_q <= pwdata[iabm_pkg::AVR_LSB +: iabm_pkg::LEVELS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bwe_q <= iabm_pkg::BWE_RESET;
      bml_q <= iabm_pkg::BML_RESET;
    end else if (wr_en && paddr == iabm_pkg::OFF_PROTECTION_CONFIG) begin
      bwe_q <= pwdata[iabm_pkg::BWE_BIT];
      bml_q <= pwdata[iabm_pkg::BML_LSB +: iabm_pkg::BML_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      timer_vec_q <= iabm_pkg::TIMER_VEC_RESET;
      watchdog_vec_q <= iabm_pkg::WATCHDOG_VEC_RESET;
    end else if (wr_en && paddr == iabm_pkg::OFF_TIMER_VECTOR) begin
      timer_vec_q <= pwdata[iabm_pkg::VEC_W-1:0];
    end else if (wr_en && paddr == iabm_pkg::OFF_WATCHDOG_VECTOR) begin
      watchdog_vec_q <= pwdata[iabm_pkg::VEC_W-1:0];
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  assign st_clear_timeout = wr_en && paddr == iabm_pkg::OFF_STATUS && pwdata[iabm_pkg::ST_TIMEOUT_BIT];
  assign st_clear_spurious = wr_en && paddr == iabm_pkg::OFF_STATUS && pwdata[iabm_pkg::ST_SPURIOUS_BIT];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      timeout_seen_q <= 1'b0;
      spurious_seen_q <= 1'b0;
    end else begin
      if (bm_expired) begin
        timeout_seen_q <= 1'b1;
      end else if (st_clear_timeout) begin
        timeout_seen_q <= 1'b0;
      end
      if (ack_start && spurious_hit) begin
        spurious_seen_q <= 1'b1;
      end else if (st_clear_spurious) begin
        spurious_seen_q <= 1'b0;
      end
    end
  end

  // Pending levels from every source, presented to the core
  always_comb begin
    for (int l = 1; l <= iabm_pkg::LEVELS; l++) begin
      pending[l-1] = external_request_lines[l-1]
                   || (timer_req && timer_level == 3'(l))
                   || (watchdog_req && watchdog_level == 3'(l))
                   || (cpm_req && cpm_level == 3'(l));
    end
  end

  iabm_level_encoder #(
    .N(iabm_pkg::LEVELS)
  ) u_level_encoder (
    .pending(pending),
    .level(ipl_out)
  );

  // Acknowledge arbitration at the acknowledged level
  always_comb begin
    logic lvl_ok;
    logic wd_hit;
    logic tm_hit;
    logic ex_hit;
    logic cp_hit;
    logic sim_wins;
    lvl_ok = iack_level != 3'h0;
    wd_hit = lvl_ok && watchdog_req && watchdog_level == iack_level;
    tm_hit = lvl_ok && timer_req && timer_level == iack_level;
    ex_hit = lvl_ok && external_request_lines[3'(iack_level - 3'h1)];
    cp_hit = lvl_ok && cpm_req && cpm_level == iack_level;
    sim_wins = (wd_hit || tm_hit || ex_hit) && (!cp_hit || arb_q > iabm_pkg::CPM_ARB);
    winner_d = iabm_pkg::IABM_WIN_SPURIOUS;
    if (sim_wins) begin
      if (wd_hit) begin
        winner_d = iabm_pkg::IABM_WIN_WATCHDOG;
      end else if (tm_hit) begin
        winner_d = iabm_pkg::IABM_WIN_TIMER;
      end else if (avr_q[3'(iack_level - 3'h1)]) begin
        winner_d = iabm_pkg::IABM_WIN_EXT_AUTO;
      end else begin
        winner_d = iabm_pkg::IABM_WIN_EXT_VEC;
      end
    end else if (cp_hit) begin
      winner_d = iabm_pkg::IABM_WIN_CPM;
    end
  end

  assign spurious_hit = winner_d == iabm_pkg::IABM_WIN_SPURIOUS;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      winner_q <= iabm_pkg::IABM_WIN_NONE;
    end else if (ack_start) begin
      winner_q <= winner_d;
    end
  end

  // Bus cycle sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      iabm_pkg::IABM_ST_IDLE: begin
        if (address_strobe && iack_cycle) begin
          state_d = iabm_pkg::IABM_ST_ACK;
        end else if (address_strobe) begin
          state_d = iabm_pkg::IABM_ST_BUS;
        end
      end
      iabm_pkg::IABM_ST_ACK,
      iabm_pkg::IABM_ST_BUS: begin
        if (!address_strobe) begin
          state_d = iabm_pkg::IABM_ST_IDLE;
        end
      end
      default: begin
        state_d = iabm_pkg::IABM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= iabm_pkg::IABM_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Response drivers; only the winner goes on the bus, the rest stay off
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      vector_q <= '0;
      vector_valid_q <= 1'b0;
      autovector_q <= 1'b0;
      cpm_grant_q <= 1'b0;
      ext_grant_q <= 1'b0;
    end else if (ack_start) begin
      vector_q <= '0;
      vector_valid_q <= 1'b0;
      autovector_q <= 1'b0;
      cpm_grant_q <= 1'b0;
      ext_grant_q <= 1'b0;
      unique case (winner_d)
        iabm_pkg::IABM_WIN_WATCHDOG: begin
          vector_q <= watchdog_vec_q;
          vector_valid_q <= 1'b1;
        end
        iabm_pkg::IABM_WIN_TIMER: begin
          vector_q <= timer_vec_q;
          vector_valid_q <= 1'b1;
        end
        iabm_pkg::IABM_WIN_EXT_AUTO: begin
          autovector_q <= 1'b1;
        end
        iabm_pkg::IABM_WIN_EXT_VEC: begin
          ext_grant_q <= 1'b1;
        end
        iabm_pkg::IABM_WIN_CPM: begin
          cpm_grant_q <= 1'b1;
        end
        default: begin
          vector_valid_q <= 1'b0;
        end
      endcase
    end else if (!address_strobe) begin
      vector_valid_q <= 1'b0;
      autovector_q <= 1'b0;
      cpm_grant_q <= 1'b0;
      ext_grant_q <= 1'b0;
    end
  end

  assign vector_out = vector_q;
  assign vector_valid = vector_valid_q;
  assign autovector_out = autovector_q;
  assign cpm_grant = cpm_grant_q;
  assign ext_grant = ext_grant_q;

  // Any termination stops timing; our own answers count as well
  assign terminated = data_size_acknowledge || bus_error_in || stop_request
                    || (iack_cycle && autovector_request)
                    || vector_valid_q || autovector_q || bus_error_signal_q;
  assign bm_run = bwe_q && address_strobe && !terminated;
  assign bm_limit = iabm_pkg::BM_BASE_CYCLES << bml_q;

  iabm_bus_watch u_bus_watch (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(bm_run),
    .limit(bm_limit),
    .expired(bm_expired)
  );

  // Bus error held until the strobe negates
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bus_error_signal_q <= 1'b0;
    end else if (bm_expired) begin
      bus_error_signal_q <= 1'b1;
    end else if (ack_start && spurious_hit) begin
      bus_error_signal_q <= 1'b1;
    end else if (!address_strobe) begin
      bus_error_signal_q <= 1'b0;
    end
  end

  assign bus_error_signal = bus_error_signal_q;

endmodule // iabm_top

// ### testbench/iabm_monitor.sv
module iabm_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic address_strobe,
  input wire logic iack_cycle,
  input wire logic [2:0] iack_level,
  input wire logic timer_req,
  input wire logic [2:0] timer_level,
  input wire logic watchdog_req,
  input wire logic [2:0] watchdog_level,
  input wire logic [iabm_pkg::LEVELS-1:0] external_request_lines,
  input wire logic cpm_req,
  input wire logic [2:0] cpm_level,
  input wire logic vector_valid,
  input wire logic autovector_out,
  input wire logic cpm_grant,
  input wire logic ext_grant,
  input wire logic bus_error_signal
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cnt_q;
  logic go, wd, tm, cp;
  // Zero count with strobe high marks the edge that takes an acknowledge cycle
  assign go = address_strobe && (cnt_q == 12'h000) && iack_cycle;
  assign wd = watchdog_req && (watchdog_level == iack_level);
  assign tm = timer_req && (timer_level == iack_level);
  assign cp = cpm_req && (cpm_level == iack_level);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge sys_clk) begin
    if (!nrst || !address_strobe)
      cnt_q <= 12'h000;
    else
      cnt_q <= cnt_q + 12'h001;
  end
  property p_wd;
    go && wd && !cp |=> vector_valid && !autovector_out && !ext_grant;
  endproperty
  a_wd: assert property (p_wd)
    else $error("watchdog not vectored");
  property p_tm;
    go && tm && !wd && !cp |=> vector_valid && !autovector_out && !ext_grant;
  endproperty
  a_tm: assert property (p_tm)
    else $error("timer not vectored");
  property p_ext;
    go && !wd && !tm && !cp && iack_level != 3'h0 && external_request_lines[iack_level - 3'h1]
      |=> (autovector_out != ext_grant) && !vector_valid;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external level unanswered");
  property p_cpm;
    go && cp && tm && !wd |=> cpm_grant != vector_valid;
  endproperty
  a_cpm: assert property (p_cpm)
    else $error("peer arbitration broken");
  property p_spur;
    go && iack_level == 3'h0 |=> bus_error_signal && !vector_valid && !autovector_out;
  endproperty
  a_spur: assert property (p_spur)
    else $error("spurious cycle not ended");
  property p_hold;
    $fell(address_strobe) |=> !(vector_valid || autovector_out || cpm_grant || ext_grant || bus_error_signal);
  endproperty
  a_hold: assert property (p_hold)
    else $error("response outlives strobe");
  property p_bw;
    $rose(bus_error_signal) && cnt_q > 12'h002 |-> cnt_q >= 12'h080;
  endproperty
  a_bw: assert property (p_bw)
    else $error("bus watch fired early");
  property p_one;
    vector_valid |-> !autovector_out && !cpm_grant && !ext_grant;
  endproperty
  a_one: assert property (p_one)
    else $error("two responders");
endmodule // iabm_monitor

bind iabm_top iabm_monitor i_mon (.sys_clk, .nrst, .address_strobe, .iack_cycle, .iack_level, .timer_req,
  .timer_level, .watchdog_req, .watchdog_level, .external_request_lines, .cpm_req, .cpm_level, .vector_valid,
  .autovector_out, .cpm_grant, .ext_grant, .bus_error_signal);

// ### testbench/iabm_core_model.sv
module iabm_core_model (
  input wire logic sys_clk,
  input wire logic vector_valid,
  input wire logic [7:0] vector_out,
  input wire logic autovector_out,
  input wire logic cpm_grant,
  input wire logic ext_grant,
  input wire logic bus_error_signal,
  output logic address_strobe,
  output logic iack_cycle,
  output logic [2:0] iack_level,
  output logic data_size_acknowledge,
  output logic bus_error_in,
  output logic stop_request,
  output logic autovector_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] seen;
  logic [7:0] seen_vec;
  int seen_cyc;
  initial begin
    {address_strobe, iack_cycle, data_size_acknowledge, bus_error_in, stop_request, autovector_request} = 6'h00;
    iack_level = 3'h0;
  end
  // Kind 1..3 ends the cycle itself at term_at; dly sets how slowly a granted far party answers
  task automatic run(input logic iack, input logic [2:0] lvl, input int term_at, input int kind, input int dly,
    input logic av);
    logic done;
    int n;
    done = 1'b0;
    n = 0;
    seen = 5'h00;
    seen_vec = 8'h00;
    {address_strobe, iack_cycle, iack_level} <= {1'b1, iack, lvl};
    while (!done && n < 2000) begin
      @(posedge sys_clk);
      n++;
      seen = seen | {bus_error_signal, ext_grant, cpm_grant, autovector_out, vector_valid};
      if (vector_valid)
        seen_vec = vector_out;
      done = vector_valid || autovector_out || bus_error_signal || data_size_acknowledge || bus_error_in ||
        stop_request || autovector_request;
      if (!done && n == term_at)
        {data_size_acknowledge, bus_error_in, stop_request} <= {kind == 1, kind == 2, kind == 3};
      if (!done && (ext_grant || cpm_grant) && n >= dly)
        {autovector_request, data_size_acknowledge} <= {ext_grant && av, !(ext_grant && av)};
    end
    seen_cyc = n;
    // Level lines show a stale-free pattern once released
    {address_strobe, iack_cycle, iack_level} <= {1'b0, 1'b0, ~lvl};
    {data_size_acknowledge, bus_error_in, stop_request, autovector_request} <= 4'h0;
    @(posedge sys_clk);
  endtask
endmodule // iabm_core_model

// ### testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, timer_req, watchdog_req, cpm_req;
  logic vector_valid, autovector_out, cpm_grant, ext_grant, bus_error_signal, slverr_seen;
  logic address_strobe, iack_cycle, data_size_acknowledge, bus_error_in, stop_request, autovector_request;
  logic [2:0] iack_level, timer_level, watchdog_level, cpm_level, ipl_out;
  logic [6:0] external_request_lines;
  logic [7:0] paddr, vector_out;
  logic [31:0] pwdata, prdata, rd;
  int err_count, checks_done;
  iabm_top i_dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .address_strobe, .iack_cycle, .iack_level, .data_size_acknowledge, .bus_error_in, .stop_request,
    .autovector_request, .timer_req, .timer_level, .watchdog_req, .watchdog_level, .external_request_lines,
    .cpm_req, .cpm_level, .ipl_out, .vector_out, .vector_valid, .autovector_out, .cpm_grant, .ext_grant,
    .bus_error_signal);
  iabm_core_model i_core (.sys_clk, .vector_valid, .vector_out, .autovector_out, .cpm_grant, .ext_grant,
    .bus_error_signal, .address_strobe, .iack_cycle, .iack_level, .data_size_acknowledge, .bus_error_in,
    .stop_request, .autovector_request);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    slverr_seen = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task automatic ack(input logic [2:0] l, input int dly, input logic av, input logic [4:0] s, input logic [7:0] v);
    i_core.run(1'b1, l, 0, 0, dly, av);
    check("ack response", {i_core.seen, i_core.seen_vec}, {s, v});
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    err_count++;
    final_report();
  end
  initial begin
    logic [31:0] rst_val [6];
    rst_val = '{32'(iabm_pkg::ARB_RESET), 32'(iabm_pkg::AVR_RESET),
      (32'(iabm_pkg::BWE_RESET) << iabm_pkg::BWE_BIT) | (32'(iabm_pkg::BML_RESET) << iabm_pkg::BML_LSB),
      32'(iabm_pkg::TIMER_VEC_RESET), 32'(iabm_pkg::WATCHDOG_VEC_RESET), 32'h0};
    {nrst, psel, penable, pwrite, timer_req, watchdog_req, cpm_req} = 7'h00;
    {paddr, pwdata, timer_level, watchdog_level, cpm_level, external_request_lines} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check("reset value", rd, rst_val[i]);
    end
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", 32'(slverr_seen), 32'h1);
    apb(1'b1, iabm_pkg::OFF_TIMER_VECTOR, 32'h41);
    apb(1'b1, iabm_pkg::OFF_WATCHDOG_VECTOR, 32'h52);
    {watchdog_req, watchdog_level, timer_req, timer_level, external_request_lines} <= {4'hf, 4'hf, 7'h40};
    ack(3'h7, 1, 1'b1, 5'h01, 8'h52);
    check("level 7 shown", 32'(ipl_out), 32'h7);
    watchdog_req <= 1'b0;
    ack(3'h7, 1, 1'b1, 5'h01, 8'h41);
    timer_req <= 1'b0;
    ack(3'h7, 1, 1'b1, 5'h08, 8'h00);
    {timer_req, timer_level, external_request_lines} <= {4'hb, 7'h04};
    ack(3'h3, 1, 1'b1, 5'h01, 8'h41);
    check("level 3 shown", 32'(ipl_out), 32'h3);
    timer_req <= 1'b0;
    apb(1'b1, iabm_pkg::OFF_AUTOVECTOR_SELECT, 32'h55);
    for (int l = 1; l < 8; l++) begin
      external_request_lines <= 7'(1 << (l - 1));
      ack(3'(l), 2, 1'b0, ((32'h55 >> (l - 1)) & 1) ? 5'h02 : 5'h08, 8'h00);
    end
    {external_request_lines, cpm_req, cpm_level, timer_req, timer_level} <= {7'h00, 4'hd, 4'hd};
    ack(3'h5, 1, 1'b0, 5'h01, 8'h41);
    // Never the peer's fixed value of 8
    apb(1'b1, iabm_pkg::OFF_MODULE_CONFIG, 32'h3);
    ack(3'h5, 1, 1'b0, 5'h04, 8'h00);
    apb(1'b1, iabm_pkg::OFF_MODULE_CONFIG, 32'h9);
    ack(3'h5, 1, 1'b0, 5'h01, 8'h41);
    {cpm_req, timer_req} <= 2'b00;
    ack(3'h0, 1, 1'b0, 5'h10, 8'h00);
    ack(3'h4, 1, 1'b0, 5'h10, 8'h00);
    apb(1'b0, iabm_pkg::OFF_STATUS, 32'h0);
    check("spurious flag", rd & 32'h2, 32'h2);
    // Limit set to its 128-cycle minimum for a cycle nobody ends
    apb(1'b1, iabm_pkg::OFF_PROTECTION_CONFIG, 32'h80);
    i_core.run(1'b0, 3'h0, 0, 0, 0, 1'b0);
    check("watch 128", {i_core.seen[4], (i_core.seen_cyc inside {[128:134]})}, 2'b11);
    apb(1'b0, iabm_pkg::OFF_STATUS, 32'h0);
    check("timeout flag", rd & 32'h1, 32'h1);
    // Clear it so the later overlong acknowledge must set it again
    apb(1'b1, iabm_pkg::OFF_STATUS, 32'h1);
    apb(1'b0, iabm_pkg::OFF_STATUS, 32'h0);
    check("timeout cleared", rd & 32'h1, 32'h0);
    apb(1'b1, iabm_pkg::OFF_PROTECTION_CONFIG, 32'h10);
    i_core.run(1'b0, 3'h0, 300, 1, 0, 1'b0);
    check("watch off", i_core.seen, 5'h00);
    apb(1'b1, iabm_pkg::OFF_PROTECTION_CONFIG, 32'h90);
    for (int k = 1; k < 4; k++) begin
      i_core.run(1'b0, 3'h0, 200, k, 0, 1'b0);
      check("terminated", i_core.seen, 5'h00);
    end
    external_request_lines <= 7'h08;
    ack(3'h4, 200, 1'b1, 5'h08, 8'h00);
    ack(3'h4, 600, 1'b1, 5'h18, 8'h00);
    check("watch 256", 32'(i_core.seen_cyc inside {[256:262]}), 32'h1);
    apb(1'b0, iabm_pkg::OFF_STATUS, 32'h0);
    check("timeout again", rd & 32'h1, 32'h1);
    check("last winner", (rd >> iabm_pkg::ST_WINNER_LSB) & 32'h7, 32'(iabm_pkg::IABM_WIN_EXT_VEC));
    check("status level", (rd >> iabm_pkg::ST_IPL_LSB) & 32'h7, 32'h4);
    final_report();
  end
endmodule // tb
